// file: rtl/tofi2c_target.sv
// Notes on behaviour
// - lines only pulled low, never driven high
// - idle bus rests high, both released
// - eight-bit bytes, each followed by acknowledge
// - sample on clock rise, stable while high
// - data fall/rise with clock high: start/stop
// - answer only address byte 0x52/0x53
// - address lsb zero write, one read
// - acknowledge own address, keep direction bit
// - write bytes two and three: 16-bit index
// - shift in data, acknowledge, store at index
// - read loads register at index, sends it
// - read data changes on clock fall
// - receiver acknowledges each byte but the last read byte
// - index advances by one per data byte
// - retention idle keeps contents, ignores bus
// - enable pin low ignores bus traffic
// - select pin low selects; pulse resets port
`timescale 1ns/1ps
`default_nettype none

module tofi2c_target
  import tofi2c_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // mode pins
  input wire logic comm_enable_pin,
  input wire logic if_select_pin,
  // register space write side
  output logic wr_en,
  output logic [tofi2c_pkg::INDEX_W-1:0] wr_index,
  output logic [tofi2c_pkg::DATA_W-1:0] wr_data,
  // register space read side
  output logic [tofi2c_pkg::INDEX_W-1:0] rd_index,
  output logic rd_strobe,
  input wire logic [tofi2c_pkg::DATA_W-1:0] rd_data
);
  import tofi2c_pkg::*;

  logic scl_s;
  logic sda_s;
  logic cen_s;
  logic sel_s;

  // the clock is sampled like the data and mode pins; it is never driven from here
  tofi2c_sync #(.RST_VAL(1'b1)) u_sync_scl (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_i(scl_i),
    .level_o(scl_s)
  );

  tofi2c_sync #(.RST_VAL(1'b1)) u_sync_sda (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_i(sda_i),
    .level_o(sda_s)
  );

  tofi2c_sync #(.RST_VAL(1'b1)) u_sync_cen (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_i(comm_enable_pin),
    .level_o(cen_s)
  );

  tofi2c_sync #(.RST_VAL(1'b0)) u_sync_sel (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_i(if_select_pin),
    .level_o(sel_s)
  );

  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic addr_match;

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_cond = scl_s & scl_p_q & ~sda_p_q & sda_s;

  tofi2c_state_t st_q;
  tofi2c_state_t st_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic rw_q;
  logic rw_d;
  logic mack_q;
  logic mack_d;
  logic drv_q;
  logic drv_d;
  logic [15:0] idx_q;
  logic [15:0] idx_d;
  logic wr_en_q;
  logic wr_en_d;
  logic [15:0] wr_idx_q;
  logic [15:0] wr_idx_d;
  logic [7:0] wr_dat_q;
  logic [7:0] wr_dat_d;
  logic rd_stb_q;
  logic rd_stb_d;

  assign addr_match = (sh_q[7:1] == TARGET_ADDR7);

  always_comb
  begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ph_d = ph_q;
    rw_d = rw_q;
    mack_d = mack_q;
    drv_d = drv_q;
    idx_d = idx_q;
    wr_en_d = 1'b0;
    wr_idx_d = wr_idx_q;
    wr_dat_d = wr_dat_q;
    rd_stb_d = 1'b0;
    if (sel_s)
    begin
      // port reset while select is high
      st_d = TOFI2C_IDLE;
      bit_d = BIT_ZERO;
      sh_d = DATA_RST;
      ph_d = PH_ADDR;
      rw_d = 1'b0;
      mack_d = 1'b0;
      drv_d = 1'b0;
      idx_d = INDEX_RST;
    end
    else if (!cen_s)
    begin
      // bus ignored, contents kept
      st_d = TOFI2C_IDLE;
      drv_d = 1'b0;
    end
    else if (start_cond)
    begin
      // start or repeated start, index kept
      st_d = TOFI2C_RX;
      ph_d = PH_ADDR;
      bit_d = BIT_ZERO;
      drv_d = 1'b0;
    end
    else if (stop_cond)
    begin
      st_d = TOFI2C_IDLE;
      drv_d = 1'b0;
    end
    else
    begin
      case (st_q)
        TOFI2C_IDLE:
        begin
          drv_d = 1'b0;
        end
        TOFI2C_RX:
        begin
          if (scl_rise && bit_q != BYTE_BITS)
          begin
            sh_d = {sh_q[6:0], sda_s};
            bit_d = bit_q + BIT_ONE;
          end
          else if (scl_fall && bit_q == BYTE_BITS)
          begin
            // end of byte, acknowledge in next clock
            st_d = TOFI2C_RXACK;
            drv_d = 1'b1;
            case (ph_q)
              PH_ADDR:
              begin
                if (addr_match)
                begin
                  rw_d = sh_q[0];
                end
                else
                begin
                  st_d = TOFI2C_IDLE;
                  drv_d = 1'b0;
                end
              end
              PH_IDXH: idx_d = {sh_q, idx_q[7:0]};
              PH_IDXL: idx_d = {idx_q[15:8], sh_q};
              default:
              begin
                // store and advance, no index resent
                wr_en_d = 1'b1;
                wr_idx_d = idx_q;
                wr_dat_d = sh_q;
                idx_d = idx_q + INDEX_STEP;
              end
            endcase
          end
        end
        TOFI2C_RXACK:
        begin
          if (scl_fall)
          begin
            bit_d = BIT_ZERO;
            if (ph_q == PH_ADDR && rw_q == RW_READ)
            begin
              // first read byte follows the address byte
              st_d = TOFI2C_TX;
              sh_d = rd_data;
              drv_d = ~rd_data[7];
              rd_stb_d = 1'b1;
            end
            else
            begin
              st_d = TOFI2C_RX;
              drv_d = 1'b0;
              if (ph_q != PH_DATA)
              begin
                ph_d = ph_q + 2'h1;
              end
            end
          end
        end
        TOFI2C_TX:
        begin
          if (scl_fall)
          begin
            if (bit_q == LAST_BIT)
            begin
              // byte sent, release for the controller's acknowledge
              st_d = TOFI2C_TXACK;
              drv_d = 1'b0;
              idx_d = idx_q + INDEX_STEP;
            end
            else
            begin
              sh_d = {sh_q[6:0], 1'b0};
              drv_d = ~sh_q[6];
              bit_d = bit_q + BIT_ONE;
            end
          end
        end
        TOFI2C_TXACK:
        begin
          if (scl_rise)
          begin
            mack_d = ~sda_s;
          end
          else if (scl_fall)
          begin
            bit_d = BIT_ZERO;
            if (mack_q)
            begin
              st_d = TOFI2C_TX;
              sh_d = rd_data;
              drv_d = ~rd_data[7];
              rd_stb_d = 1'b1;
            end
            else
            begin
              st_d = TOFI2C_IDLE;
            end
          end
        end
        default:
        begin
          st_d = TOFI2C_IDLE;
          drv_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      st_q <= TOFI2C_IDLE;
      bit_q <= BIT_ZERO;
      sh_q <= DATA_RST;
      ph_q <= PH_ADDR;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      drv_q <= 1'b0;
      idx_q <= INDEX_RST;
      wr_en_q <= 1'b0;
      wr_idx_q <= INDEX_RST;
      wr_dat_q <= DATA_RST;
      rd_stb_q <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ph_q <= ph_d;
      rw_q <= rw_d;
      mack_q <= mack_d;
      drv_q <= drv_d;
      idx_q <= idx_d;
      wr_en_q <= wr_en_d;
      wr_idx_q <= wr_idx_d;
      wr_dat_q <= wr_dat_d;
      rd_stb_q <= rd_stb_d;
    end
  end

  // open drain: output low, enable low only while pulling
  assign sda_o = 1'b0;
  assign sda_oe_n = ~drv_q;
  assign wr_en = wr_en_q;
  assign wr_index = wr_idx_q;
  assign wr_data = wr_dat_q;
  assign rd_index = idx_q;
  assign rd_strobe = rd_stb_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  logic quiet;
  assign quiet = cen_s & ~sel_s & ~start_cond & ~stop_cond;

  sequence s_addr_done;
    quiet && st_q == TOFI2C_RX && ph_q == PH_ADDR && bit_q == BYTE_BITS && scl_fall;
  endsequence

  sequence s_data_done;
    quiet && st_q == TOFI2C_RX && ph_q == PH_DATA && bit_q == BYTE_BITS && scl_fall;
  endsequence

  property p_only_low;
    !sda_oe_n |-> sda_o == 1'b0 && st_q inside {TOFI2C_RXACK, TOFI2C_TX};
  endproperty
  a_only_low: assert property (p_only_low) else $error("sda not open drain");

  property p_addr_ack;
    s_addr_done and addr_match |=> !sda_oe_n && rw_q == $past(sh_q[0]);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");

  property p_addr_miss;
    s_addr_done and !addr_match |=> sda_oe_n && st_q == TOFI2C_IDLE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

  property p_data_store;
    s_data_done |=> wr_en && wr_data == $past(sh_q) && wr_index == $past(idx_q) ##1 !wr_en;
  endproperty
  a_data_store: assert property (p_data_store) else $error("data byte not stored");

  property p_index_step;
    wr_en |-> idx_q == wr_index + INDEX_STEP || $past(sel_s) || $past(start_cond);
  endproperty
  a_index_step: assert property (p_index_step) else $error("index not advanced");

  property p_tx_on_fall;
    st_q == TOFI2C_TX && quiet && !scl_fall |=> $stable(sda_oe_n);
  endproperty
  a_tx_on_fall: assert property (p_tx_on_fall) else $error("read bit moved off fall");

  property p_read_load;
    quiet && st_q == TOFI2C_RXACK && scl_fall && ph_q == PH_ADDR && rw_q
      |=> st_q == TOFI2C_TX && sh_q == $past(rd_data) && rd_strobe;
  endproperty
  a_read_load: assert property (p_read_load) else $error("read byte not loaded");

  property p_disabled;
    !cen_s |=> st_q == TOFI2C_IDLE && sda_oe_n;
  endproperty
  a_disabled: assert property (p_disabled) else $error("bus seen while disabled");

  property p_select_reset;
    sel_s |=> st_q == TOFI2C_IDLE && idx_q == INDEX_RST && sda_oe_n;
  endproperty
  a_select_reset: assert property (p_select_reset) else $error("select did not reset");

  property p_stop_idle;
    cen_s && !sel_s && stop_cond |=> st_q == TOFI2C_IDLE ##1 sda_oe_n;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

endmodule // tofi2c_target

`default_nettype wire

// file: rtl/tofi2c_pkg.sv
package tofi2c_pkg;

  // bus framing
  localparam int DATA_W = 8;
  localparam int INDEX_W = 16;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_ZERO = 4'h0;

  // own address, upper seven bits of the address byte
  localparam logic [6:0] TARGET_ADDR7 = 7'h29;
  localparam logic RW_READ = 1'b1;

  // index handling
  localparam logic [15:0] INDEX_RST = 16'h0000;
  localparam logic [15:0] INDEX_STEP = 16'h0001;
  localparam logic [7:0] DATA_RST = 8'h00;

  // position of the byte within a write message
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_IDXH = 2'h1;
  localparam logic [1:0] PH_IDXL = 2'h2;
  localparam logic [1:0] PH_DATA = 2'h3;

  // link state, one-hot
  typedef enum logic [4:0] {
    TOFI2C_IDLE = 5'h01,
    TOFI2C_RX = 5'h02,
    TOFI2C_RXACK = 5'h04,
    TOFI2C_TX = 5'h08,
    TOFI2C_TXACK = 5'h10
  } tofi2c_state_t;

endpackage : tofi2c_pkg

// file: rtl/tofi2c_sync.sv
`timescale 1ns/1ps
`default_nettype none

// three-stage input sampler; output follows once stages two and three agree
module tofi2c_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // pin side
  input wire logic pin_i,
  // clock domain side
  output logic level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  logic lvl_d;

  always_comb
  begin
    lvl_d = lvl_q;
    if (s2_q == s3_q)
    begin
      lvl_d = s3_q;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;

endmodule // tofi2c_sync

`default_nettype wire

// file: test/tofi2c_host.sv
`timescale 1ns/1ps
`default_nettype none

// bus controller model: makes the clock, lines are only ever pulled low
module tofi2c_host (
  // resolved data wire
  input wire logic sda,
  // pull-down enables
  output logic scl_pull,
  output logic sda_pull
);
  localparam realtime Q = 31.25; // quarter of a 125 ns bus clock
  realtime slow = 0.0;

  initial
  begin
    scl_pull = 1'b0; // both lines released while idle
    sda_pull = 1'b0;
  end

  // start or repeated start: data falls while clock high
  task automatic start();
    sda_pull = 1'b0;
    #Q scl_pull = 1'b0;
    #Q sda_pull = 1'b1;
    #Q scl_pull = 1'b1;
    #Q;
  endtask

  // data rises while clock high
  task automatic stop();
    sda_pull = 1'b1;
    #Q scl_pull = 1'b0;
    #Q sda_pull = 1'b0;
    #(2*Q);
  endtask

  // change data in clock low, sample at end of high
  task automatic bit_x(input logic b, output logic r);
    sda_pull = ~b;
    #(Q+slow) scl_pull = 1'b0;
    #(2*Q) r = sda;
    scl_pull = 1'b1;
    #Q;
  endtask

  // msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(ack_in, ack_out);
  endtask
endmodule // tofi2c_host

`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import tofi2c_pkg::*;
  logic sys_clk, arst_n, comm_enable_pin, if_select_pin;
  logic scl_pull, sda_pull, sda_o, sda_oe_n, wr_en, rd_strobe;
  logic [15:0] wr_index, rd_index, idx, nx;
  logic [7:0] wr_data;
  logic [7:0] bad [3] = '{8'h50, 8'h56, 8'hd2};
  logic [31:0] seed;
  logic [23:0] wq[$];
  wire logic scl_i, sda_i;
  wire logic [7:0] rd_data;
  int n_fail, n_checks, n_stb;

  function automatic logic [7:0] reg_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // pull-ups on both wires
  assign scl_i = ~scl_pull;
  assign sda_i = ~(sda_pull | ~sda_oe_n);
  assign rd_data = reg_val(rd_index);

  tofi2c_target i_tofi2c_target (.sys_clk(sys_clk), .arst_n(arst_n), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .comm_enable_pin(comm_enable_pin),
    .if_select_pin(if_select_pin), .wr_en(wr_en), .wr_index(wr_index), .wr_data(wr_data),
    .rd_index(rd_index), .rd_strobe(rd_strobe), .rd_data(rd_data));
  tofi2c_host i_tofi2c_host (.sda(sda_i), .scl_pull(scl_pull), .sda_pull(sda_pull));

  task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    chk_val(nm, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic tx(input logic [7:0] d, input logic exp_ack);
    logic [7:0] r;
    logic a;
    i_tofi2c_host.xfer(d, 1'b1, r, a);
    chk_bit("target ack", exp_ack, a);
  endtask

  // address, index pair, then a burst of n data bytes
  task automatic wr_msg(input logic [15:0] ix, input int n, input logic ok);
    logic [7:0] d;
    i_tofi2c_host.start();
    tx(8'h52, ~ok);
    tx(ix[15:8], ~ok);
    tx(ix[7:0], ~ok);
    for (int k = 0; k < n; k++)
    begin
      d = 8'(rnd());
      if (ok)
        wq.push_back({ix + 16'(k), d});
      tx(d, ~ok);
    end
  endtask

  // n bytes read from ix onward, the last one refused by the controller
  task automatic rd_msg(input logic [15:0] ix, input int n);
    logic [7:0] r;
    logic a;
    int s0;
    s0 = n_stb;
    i_tofi2c_host.start();
    tx(8'h53, 1'b0);
    for (int k = 0; k < n; k++)
    begin
      i_tofi2c_host.xfer(8'hff, k == n - 1, r, a);
      chk_val("read byte", {8'h00, reg_val(ix + 16'(k))}, {8'h00, r});
    end
    chk_val("read strobes", 16'(n), 16'(n_stb - s0));
    i_tofi2c_host.stop();
    chk_bit("idle data line", 1'b1, sda_i);
    chk_bit("data out level", 1'b0, sda_o);
    nx = ix + 16'(n);
  endtask

  // one read strobe per byte handed to the controller
  always @(negedge sys_clk)
    if (rd_strobe === 1'b1)
      n_stb++;

  always @(negedge sys_clk)
    if (wr_en === 1'b1)
    begin
      if (wq.size() == 0)
        chk_bit("unexpected write", 1'b0, 1'b1);
      else
      begin
        chk_val("write index", wq[0][23:8], wr_index);
        chk_val("write data", {8'h00, wq[0][7:0]}, {8'h00, wr_data});
        void'(wq.pop_front());
      end
    end

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #500000;
    n_fail++;
    final_report();
  end

  initial
  begin
    n_fail = 0;
    n_checks = 0;
    n_stb = 0;
    seed = 32'h00000015;
    arst_n = 1'b0;
    comm_enable_pin = 1'b1;
    if_select_pin = 1'b0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    // random bursts, read back after aiming the index, the first across the wrap
    for (int t = 0; t < 4; t++)
    begin
      idx = (t == 0) ? 16'hffff : 16'(rnd());
      wr_msg(idx, t + 1, 1'b1);
      i_tofi2c_host.stop();
      wr_msg(idx, 0, 1'b1);
      rd_msg(idx, t + 2);
    end
    rd_msg(nx, 2);
    foreach (bad[j])
    begin
      i_tofi2c_host.start();
      tx(bad[j], 1'b1);
      i_tofi2c_host.stop();
    end
    // slow controller
    i_tofi2c_host.slow = 400.0;
    wr_msg(16'h0100, 2, 1'b1);
    // the burst left the index two past its start
    rd_msg(16'h0102, 3);
    i_tofi2c_host.slow = 0.0;
    // disabled port ignores traffic and keeps the index
    @(posedge sys_clk) comm_enable_pin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    wr_msg(16'h1234, 2, 1'b0);
    i_tofi2c_host.stop();
    @(posedge sys_clk) comm_enable_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd_msg(nx, 1);
    // select pulse resets the port logic
    @(posedge sys_clk) if_select_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    if_select_pin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd_msg(16'h0000, 2);
    chk_val("pending writes", 16'h0000, 16'(wq.size()));
    final_report();
  end
endmodule // testbench

`default_nettype wire
